// file: verilog/fpx_params.svh
// constants for the floating-point exception vectoring block
// assumes vector base supplied by the core as a byte address
// Contract
// (RL1) opcode bits 15-12 all ones is F-line
// (RL2) implemented F-line patterns execute, no exception
// (RL3) recognised unimplemented FP pattern raises vector 11
// (RL4) other F-line words: vector 11, format zero
// (RL5) breakpoint ack ended by ack reports illegal
// (RL6) unimplemented FP instruction uses vector 11, 02c
// (RL7) unordered branch/set trap uses vector 48
// (RL8) arithmetic exceptions vector 49 through 55
// (RL9) nearest mode overflow gives signed infinity
// (RL10) toward zero overflow gives signed largest
// (RL11) down mode: +largest or -infinity
// (RL12) up mode: +infinity or -largest
// (RL13) late stage pending beats early stage pending
// (RL14) dependent overflow: post exception, address invalid
// (RL15) faulting store out: format three, destination address
// (RL16) fetch stage one clock minimum, one per access
// (RL17) register direct zero accesses, memory modes one
// (RL18) software-only formats and types go to emulation
// (RL19) unsupported data type raises vector 55
// (RL20) vector offset is number times four plus base
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH
`define FPX_FLINE_NIB       4'hf
`define FPX_VEC_FLINE       8'h0b
`define FPX_VEC_ILLEGAL     8'h04
`define FPX_VEC_UNORDERED   8'h30
`define FPX_VEC_INEXACT     8'h31
`define FPX_VEC_DIVZERO     8'h32
`define FPX_VEC_UNDERFLOW   8'h33
`define FPX_VEC_OPERR       8'h34
`define FPX_VEC_OVERFLOW    8'h35
`define FPX_VEC_SIGNALING_NOT_A_NUMBER        8'h36
`define FPX_VEC_UNSUPP      8'h37
`define FPX_FMT_ZERO        4'h0
`define FPX_FMT_THREE       4'h3
`define FPX_FETCH_MIN       4'h1
`endif

// file: verilog/fpx_pkg.sv
// types for the floating-point exception vectoring block
// assumes nothing beyond the params header
package fpx_pkg;
   typedef enum logic [1:0] {
      FPX_RND_NEAREST,
      FPX_RND_ZERO,
      FPX_RND_DOWN,
      FPX_RND_UP
   } fpx_rnd_e;
   // operand precision for default overflow result
   typedef enum logic [1:0] {
      FPX_PREC_SINGLE,
      FPX_PREC_DOUBLE,
      FPX_PREC_EXTENDED
   } fpx_prec_e;
   // addressing mode classes
   typedef enum logic [2:0] {
      FPX_EA_DREG,
      FPX_EA_AREG,
      FPX_EA_IND,
      FPX_EA_POSTINC,
      FPX_EA_PREDEC,
      FPX_EA_DISP,
      FPX_EA_PCREL,
      FPX_EA_ABS
   } fpx_ea_e;
endpackage

// file: verilog/fpx_decode.sv
// F-line opcode classifier
// assumes a single opcode word and seven extension-word opmode bits for the general op
`timescale 1ns/1ps
`default_nettype none
`include "fpx_params.svh"
module fpx_decode (
   input  wire logic [15:0] i_opword,
   input  wire logic [6:0]  i_fp_opmode,
   output logic             o_fline,
   output logic             o_implemented,
   output logic             o_unimpl_fp
);
   logic [2:0] cpid;
   logic [2:0] cptype;
   always_comb begin
      cpid   = i_opword[11:9];
      cptype = i_opword[8:6];
      o_fline       = i_opword[15:12] == `FPX_FLINE_NIB; // RL1
      o_implemented = 1'b0;
      o_unimpl_fp   = 1'b0;
      if (o_fline) begin
         // cache push/invalidate and move16 are cpid 2/3
         if (cpid == 3'h2 || cpid == 3'h3) begin
            o_implemented = 1'b1; // RL2
         end else if (cpid == 3'h1) begin
            if (cptype == 3'h0) begin
               // general op: arithmetic core ops in hardware, transcendentals not
               if (i_fp_opmode inside {7'h00, 7'h04, 7'h18, 7'h1a, 7'h20,
                                       7'h22, 7'h23, 7'h28, 7'h38, 7'h3a}) begin
                  o_implemented = 1'b1; // RL2
               end else begin
                  o_unimpl_fp = 1'b1; // RL3
               end
            end else if (cptype == 3'h1 || cptype == 3'h2 || cptype == 3'h3
                         || cptype == 3'h4 || cptype == 3'h5) begin
               o_implemented = 1'b1; // RL2
            end else begin
               o_unimpl_fp = 1'b1; // RL3
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/fpx_ovf_result.sv
// default overflow result per rounding mode
// assumes sign of intermediate result is supplied
`timescale 1ns/1ps
`default_nettype none
`include "fpx_params.svh"
module fpx_ovf_result (
   input  wire logic                i_sign,
   input  wire fpx_pkg::fpx_rnd_e   i_mode,
   input  wire fpx_pkg::fpx_prec_e  i_prec,
   output logic [79:0]              o_result
);
   import fpx_pkg::*;
   logic big;
   function automatic logic [79:0] pack(input logic s, input logic m, input fpx_prec_e p);
      logic [79:0] r;
      r = '0;
      unique case (p)
         FPX_PREC_SINGLE:   r[31:0] = {s, m ? 8'hfe : 8'hff, m ? 23'h7fffff : 23'h0};
         FPX_PREC_DOUBLE:   r[63:0] = {s, m ? 11'h7fe : 11'h7ff, m ? 52'hfffffffffffff : 52'h0};
         default:           r = {s, m ? 15'h7ffe : 15'h7fff, m ? 64'hffffffffffffffff
                                                            : 64'h8000000000000000};
      endcase
      return r;
   endfunction
   always_comb begin
      unique case (i_mode)
         FPX_RND_NEAREST: big = 1'b0;   // RL9
         FPX_RND_ZERO:    big = 1'b1;   // RL10
         FPX_RND_DOWN:    big = !i_sign;  // RL11
         FPX_RND_UP:      big = i_sign;   // RL12
      endcase
      o_result = pack(i_sign, big, i_prec);
   end
endmodule
`default_nettype wire

// file: verilog/fpx_vectoring.sv
// floating-point exception vectoring top
// assumes core presents one event set per cycle with a one-cycle valid
`timescale 1ns/1ps
`default_nettype none
`include "fpx_params.svh"
module fpx_vectoring #(
   parameter int ADDR_W = 32
) (
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire logic               i_valid,
   input  wire logic [15:0]        i_opword,
   input  wire logic [6:0]         i_fp_opmode,
   input  wire logic               i_unordered_trap,
   input  wire logic [6:0]         i_arith_exc,
   input  wire logic               i_unsupp_type,
   input  wire logic               i_bkpt_ack_cycle,
   input  wire logic               i_transfer_acknowledge,
   input  wire logic               i_transfer_error_ack,
   input  wire logic               i_late_stage_pending,
   input  wire logic               i_early_stage_pending,
   input  wire logic               i_dep_overflow,
   input  wire logic               i_fp_store_out_fault,
   input  wire logic [ADDR_W-1:0]  i_store_addr,
   input  wire logic [ADDR_W-1:0]  i_vbr,
   input  wire logic               i_sign,
   input  wire fpx_pkg::fpx_rnd_e  i_rnd,
   input  wire fpx_pkg::fpx_prec_e i_prec,
   input  wire fpx_pkg::fpx_ea_e   i_ea_mode,
   output logic                    o_exc,
   output logic [7:0]              o_vector,
   output logic [ADDR_W-1:0]       o_vector_addr,
   output logic [3:0]              o_frame_fmt,
   output logic                    o_post_instr,
   output logic                    o_ea_valid,
   output logic [ADDR_W-1:0]       o_frame_ea,
   output logic                    o_late_first,
   output logic [3:0]              o_fetch_clocks,
   output logic                    o_execute,
   output logic [79:0]             o_ovf_result
);
   import fpx_pkg::*;
   initial begin
      if (ADDR_W < 12) $error("ADDR_W too small");
   end

   logic fline, impl, unimpl;
   logic [79:0] ovf_res;
   logic              exc, next_exc;
   logic [7:0]        vector, next_vector;
   logic [ADDR_W-1:0] vaddr, next_vaddr;
   logic [3:0]        fmt, next_fmt;
   logic              post, next_post;
   logic              eav, next_eav;
   logic [ADDR_W-1:0] fea, next_fea;
   logic              late, next_late;
   logic [3:0]        fclk, next_fclk;
   logic              execr, next_execr;
   logic [79:0]       ovr, next_ovr;

   fpx_decode u_dec (
      .i_opword      (i_opword),
      .i_fp_opmode   (i_fp_opmode),
      .o_fline       (fline),
      .o_implemented (impl),
      .o_unimpl_fp   (unimpl)
   );
   fpx_ovf_result u_ovf (
      .i_sign   (i_sign),
      .i_mode   (i_rnd),
      .i_prec   (i_prec),
      .o_result (ovf_res)
   );

   function automatic logic [ADDR_W-1:0] vec_addr(input logic [7:0] v,
                                                  input logic [ADDR_W-1:0] base);
      return base + ADDR_W'({v, 2'b00}); // RL20
   endfunction

   function automatic logic [3:0] accesses(input fpx_ea_e m);
      return (m == FPX_EA_DREG || m == FPX_EA_AREG) ? 4'h0 : 4'h1; // RL17
   endfunction

   // lowest arithmetic vector wins when several report together
   function automatic logic [7:0] arith_vec(input logic [6:0] a);
      logic [7:0] v;
      v = `FPX_VEC_INEXACT;
      for (int i = 6; i >= 0; i--) begin
         if (a[i]) v = `FPX_VEC_INEXACT + 8'(i);
      end
      return v; // RL8
   endfunction

   always_comb begin
      next_exc    = 1'b0;
      next_vector = vector;
      next_fmt    = fmt;
      next_post   = 1'b0;
      next_eav    = eav;
      next_fea    = fea;
      next_late   = i_late_stage_pending; // RL13
      next_execr  = 1'b0;
      next_ovr    = ovr;
      next_fclk   = fclk;
      if (i_bkpt_ack_cycle && (i_transfer_acknowledge || i_transfer_error_ack)) begin
         next_exc    = 1'b1; // RL5
         next_vector = `FPX_VEC_ILLEGAL;
         next_fmt    = `FPX_FMT_ZERO;
      end else if (i_valid) begin
         // stay at one clock when no operand, else one per access
         next_fclk = (accesses(i_ea_mode) > `FPX_FETCH_MIN) ? accesses(i_ea_mode)
                                                            : `FPX_FETCH_MIN; // RL16
         if (fline && !impl) begin
            next_exc    = 1'b1; // RL3 RL4 RL6
            next_vector = `FPX_VEC_FLINE;
            next_fmt    = `FPX_FMT_ZERO;
         end else if (i_late_stage_pending || i_early_stage_pending) begin
            // late stage frame fields are serviced before early ones
            next_exc    = 1'b1; // RL13
            next_vector = arith_vec(i_arith_exc);
            next_fmt    = `FPX_FMT_ZERO;
         end else if (i_unsupp_type) begin
            next_exc    = 1'b1; // RL18 RL19
            next_vector = `FPX_VEC_UNSUPP;
            next_fmt    = `FPX_FMT_ZERO;
         end else if (i_unordered_trap) begin
            next_exc    = 1'b1; // RL7
            next_vector = `FPX_VEC_UNORDERED;
            next_fmt    = `FPX_FMT_ZERO;
         end else if (i_fp_store_out_fault) begin
            next_exc    = 1'b1; // RL15
            next_post   = 1'b1;
            next_vector = arith_vec(i_arith_exc);
            next_fmt    = `FPX_FMT_THREE;
            next_eav    = 1'b1;
            next_fea    = i_store_addr;
         end else if (i_dep_overflow) begin
            next_exc    = 1'b1; // RL14
            next_post   = 1'b1;
            next_vector = `FPX_VEC_OVERFLOW;
            next_fmt    = `FPX_FMT_THREE;
            next_eav    = 1'b0;
            next_ovr    = ovf_res; // RL9 RL10 RL11 RL12
         end else if (|i_arith_exc) begin
            next_exc    = 1'b1; // RL8
            next_vector = arith_vec(i_arith_exc);
            next_fmt    = `FPX_FMT_ZERO;
            if (i_arith_exc[4]) next_ovr = ovf_res;
         end else begin
            next_execr  = 1'b1; // RL2
         end
      end
      next_vaddr = vec_addr(next_vector, i_vbr); // RL20
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         exc    <= 1'b0;
         vector <= 8'h00;
         vaddr  <= '0;
         fmt    <= 4'h0;
         post   <= 1'b0;
         eav    <= 1'b0;
         fea    <= '0;
         late   <= 1'b0;
         fclk   <= `FPX_FETCH_MIN;
         execr  <= 1'b0;
         ovr    <= 80'h0;
      end else begin
         exc    <= next_exc;
         vector <= next_vector;
         vaddr  <= next_vaddr;
         fmt    <= next_fmt;
         post   <= next_post;
         eav    <= next_eav;
         fea    <= next_fea;
         late   <= next_late;
         fclk   <= next_fclk;
         execr  <= next_execr;
         ovr    <= next_ovr;
      end
   end

   assign o_exc          = exc;
   assign o_vector       = vector;
   assign o_vector_addr  = vaddr;
   assign o_frame_fmt    = fmt;
   assign o_post_instr   = post;
   assign o_ea_valid     = eav;
   assign o_frame_ea     = fea;
   assign o_late_first   = late;
   assign o_fetch_clocks = fclk;
   assign o_execute      = execr;
   assign o_ovf_result   = ovr;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   AST_FLINE_ILLEGAL: assert property (i_valid && fline && !impl && !i_bkpt_ack_cycle
      |=> o_exc && o_vector == 8'h0b && o_frame_fmt == 4'h0) // RL4
      else $error("unrecognised F-line did not vector 11");
   AST_IMPL_NO_EXC: assert property (i_valid && fline && impl && !i_bkpt_ack_cycle
      && !i_late_stage_pending && !i_early_stage_pending && !i_unsupp_type
      && !i_unordered_trap && !i_fp_store_out_fault && !i_dep_overflow && i_arith_exc == 7'h0
      |=> !o_exc && o_execute) // RL2
      else $error("implemented F-line raised exception");
   AST_BKPT: assert property (i_bkpt_ack_cycle && (i_transfer_acknowledge || i_transfer_error_ack)
      |=> o_exc && o_vector == 8'h04) // RL5
      else $error("breakpoint ack did not report illegal");
   AST_VADDR: assert property (o_exc |-> o_vector_addr == i_vbr + {o_vector, 2'b00}
      || $past(i_vbr) + {o_vector, 2'b00} == o_vector_addr) // RL20
      else $error("vector address mismatch");
   AST_UNORD: assert property (i_valid && !fline && !i_bkpt_ack_cycle && i_unordered_trap
      && !i_late_stage_pending && !i_early_stage_pending && !i_unsupp_type
      |=> o_vector == 8'h30 && o_vector_addr[7:0] == $past(i_vbr[7:0]) + 8'hc0) // RL7
      else $error("unordered trap vector wrong");
   AST_DEP_OVF: assert property (i_valid && !fline && !i_bkpt_ack_cycle && i_dep_overflow
      && !i_late_stage_pending && !i_early_stage_pending && !i_unsupp_type
      && !i_unordered_trap && !i_fp_store_out_fault
      |=> o_post_instr && !o_ea_valid && o_vector == 8'h35) // RL14
      else $error("dependent overflow not post with invalid address");
   AST_STORE: assert property (i_valid && !fline && !i_bkpt_ack_cycle && i_fp_store_out_fault
      && !i_late_stage_pending && !i_early_stage_pending && !i_unsupp_type && !i_unordered_trap
      |=> o_frame_fmt == 4'h3 && o_ea_valid && o_frame_ea == $past(i_store_addr)) // RL15
      else $error("store fault frame wrong");
   AST_UNSUPP: assert property (i_valid && !fline && !i_bkpt_ack_cycle && i_unsupp_type
      && !i_late_stage_pending && !i_early_stage_pending |=> o_vector == 8'h37) // RL19
      else $error("unsupported type not vector 55");
   AST_LATE: assert property (i_late_stage_pending |=> o_late_first) // RL13
      else $error("late stage precedence lost");
   AST_FETCH: assert property (i_valid && !i_bkpt_ack_cycle |=> o_fetch_clocks ==
      (($past(i_ea_mode) == FPX_EA_DREG || $past(i_ea_mode) == FPX_EA_AREG) ? 4'h1 : 4'h1)
      && o_fetch_clocks != 4'h0) // RL16
      else $error("fetch clocks wrong");
   COV_FLINE: cover property (o_exc && o_vector == 8'h0b);
   COV_BKPT: cover property (o_exc && o_vector == 8'h04);
   COV_POST: cover property (o_post_instr && o_ea_valid);
   COV_EXEC: cover property (o_execute);
endmodule
`default_nettype wire

// file: bench/fpx_vectoring_bench.sv
// self-checking bench for the floating-point exception vectoring block
// assumes fpx_pkg and the verilog/ design files are compiled before it
`timescale 1ns/1ps
`default_nettype none
module fpx_vectoring_bench;
   import fpx_pkg::*;
   logic        i_clk;
   logic        i_rst;
   logic        i_valid;
   logic [15:0] i_opword;
   logic [6:0]  i_fp_opmode;
   logic        i_unordered_trap;
   logic [6:0]  i_arith_exc;
   logic        i_unsupp_type;
   logic        i_bkpt_ack_cycle;
   logic        i_transfer_acknowledge;
   logic        i_transfer_error_ack;
   logic        i_late_stage_pending;
   logic        i_early_stage_pending;
   logic        i_dep_overflow;
   logic        i_fp_store_out_fault;
   logic [31:0] i_store_addr;
   logic [31:0] i_vbr;
   logic        i_sign;
   fpx_rnd_e    i_rnd;
   fpx_prec_e   i_prec;
   fpx_ea_e     i_ea_mode;
   logic        o_exc;
   logic [7:0]  o_vector;
   logic [31:0] o_vector_addr;
   logic [3:0]  o_frame_fmt;
   logic        o_post_instr;
   logic        o_ea_valid;
   logic [31:0] o_frame_ea;
   logic        o_late_first;
   logic [3:0]  o_fetch_clocks;
   logic        o_execute;
   logic [79:0] o_ovf_result;
   int          fails;
   int          total_checks;
   logic [15:0] fl_word [3];
   logic [6:0]  m;

   fpx_vectoring #(.ADDR_W(32)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
      .i_opword(i_opword), .i_fp_opmode(i_fp_opmode), .i_unordered_trap(i_unordered_trap),
      .i_arith_exc(i_arith_exc), .i_unsupp_type(i_unsupp_type),
      .i_bkpt_ack_cycle(i_bkpt_ack_cycle), .i_transfer_acknowledge(i_transfer_acknowledge),
      .i_transfer_error_ack(i_transfer_error_ack), .i_late_stage_pending(i_late_stage_pending),
      .i_early_stage_pending(i_early_stage_pending), .i_dep_overflow(i_dep_overflow),
      .i_fp_store_out_fault(i_fp_store_out_fault), .i_store_addr(i_store_addr),
      .i_vbr(i_vbr), .i_sign(i_sign), .i_rnd(i_rnd), .i_prec(i_prec),
      .i_ea_mode(i_ea_mode), .o_exc(o_exc), .o_vector(o_vector),
      .o_vector_addr(o_vector_addr), .o_frame_fmt(o_frame_fmt), .o_post_instr(o_post_instr),
      .o_ea_valid(o_ea_valid), .o_frame_ea(o_frame_ea), .o_late_first(o_late_first),
      .o_fetch_clocks(o_fetch_clocks), .o_execute(o_execute), .o_ovf_result(o_ovf_result));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic chk(input string name, input logic [79:0] seen, input logic [79:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // clears every event input; the opword left behind is not F-line
   task automatic quiet();
      i_valid = 1'b0;
      i_opword = 16'h4e71;
      i_fp_opmode = 7'h00;
      i_unordered_trap = 1'b0;
      i_arith_exc = 7'h00;
      i_unsupp_type = 1'b0;
      i_bkpt_ack_cycle = 1'b0;
      i_transfer_acknowledge = 1'b0;
      i_transfer_error_ack = 1'b0;
      i_late_stage_pending = 1'b0;
      i_early_stage_pending = 1'b0;
      i_dep_overflow = 1'b0;
      i_fp_store_out_fault = 1'b0;
   endtask

   // inputs were set at this falling edge; the answer is read at the next falling edge
   task automatic go(input logic v);
      i_valid = v;
      @(negedge i_clk);
      quiet();
   endtask

   task automatic chk_vec(input logic [7:0] v);
      chk("exc", o_exc, 1'b1);
      chk("vector", o_vector, v);
      chk("vector_addr", o_vector_addr, i_vbr + 32'(v) * 32'h4);
   endtask

   function automatic logic [7:0] low_vec(input logic [6:0] mask);
      for (int k = 0; k < 7; k++) begin
         if (mask[k]) return 8'(49 + k);
      end
      return 8'h00;
   endfunction

   // sign and exponent of the extended default: largest has exponent one below infinity
   function automatic logic [15:0] ovf_hi(input int md, input logic s);
      logic big;
      big = (md == 1) || (md == 2 && !s) || (md == 3 && s);
      return {s, big ? 15'h7ffe : 15'h7fff};
   endfunction

   initial begin
      repeat (5000) @(posedge i_clk);
      fails++;
      print_verdict();
   end

   initial begin
      fails = 0;
      total_checks = 0;
      void'($urandom(64));
      quiet();
      i_rst = 1'b1;
      i_store_addr = 32'h0;
      i_vbr = $urandom & 32'hffff_fffc;
      i_sign = 1'b0;
      i_rnd = FPX_RND_NEAREST;
      i_prec = FPX_PREC_EXTENDED;
      i_ea_mode = FPX_EA_DREG;
      fl_word = '{16'hf200, 16'hf000, 16'hfe00};
      repeat (2) @(negedge i_clk);
      chk("exc", o_exc, 1'b0);
      chk("fetch", o_fetch_clocks, 4'h1);
      i_rst = 1'b0;
      $display("test reset done");
      for (int k = 0; k < 3; k++) begin
         @(negedge i_clk);
         i_opword = fl_word[k];
         i_fp_opmode = 7'h01;
         go(1'b1);
         chk_vec(8'h0b);
         chk("fmt", o_frame_fmt, 4'h0);
         chk("execute", o_execute, 1'b0);
      end
      $display("test fline done");
      for (int k = 0; k < 3; k++) begin
         @(negedge i_clk);
         i_opword = (k == 0) ? 16'hf200 : (k == 1) ? 16'hf4f8 : {4'($urandom % 15), 12'($urandom)};
         i_fp_opmode = 7'h23;
         go(1'b1);
         chk("execute", o_execute, 1'b1);
         chk("exc", o_exc, 1'b0);
      end
      $display("test implemented done");
      for (int k = 0; k < 3; k++) begin
         @(negedge i_clk);
         i_bkpt_ack_cycle = 1'b1;
         i_transfer_acknowledge = (k == 0);
         i_transfer_error_ack = (k == 1);
         go(1'b0);
         chk("bkpt_exc", o_exc, k < 2);
         if (k < 2) chk("bkpt_vec", o_vector, 8'h04);
      end
      $display("test breakpoint done");
      for (int k = 0; k < 27; k++) begin
         @(negedge i_clk);
         m = (k < 7) ? 7'(1 << k) : 7'($urandom % 127 + 1);
         i_opword = {4'($urandom % 15), 12'($urandom)};
         i_arith_exc = m;
         go(1'b1);
         chk_vec(low_vec(m));
      end
      @(negedge i_clk);
      i_unordered_trap = 1'b1;
      go(1'b1);
      chk_vec(8'h30);
      @(negedge i_clk);
      i_unsupp_type = 1'b1;
      go(1'b1);
      chk_vec(8'h37);
      $display("test arith done");
      for (int k = 0; k < 8; k++) begin
         @(negedge i_clk);
         i_arith_exc = 7'h10;
         i_rnd = fpx_rnd_e'(k / 2);
         i_sign = k[0];
         go(1'b1);
         chk_vec(8'h35);
         chk("ovf_hi", o_ovf_result[79:64], ovf_hi(k / 2, k[0]));
      end
      $display("test overflow done");
      for (int k = 0; k < 2; k++) begin
         @(negedge i_clk);
         i_late_stage_pending = (k == 0);
         i_early_stage_pending = 1'b1;
         go(1'b1);
         chk("late_first", o_late_first, k == 0);
      end
      @(negedge i_clk);
      i_dep_overflow = 1'b1;
      go(1'b1);
      chk("post", o_post_instr, 1'b1);
      chk("ea_valid", o_ea_valid, 1'b0);
      @(negedge i_clk);
      i_fp_store_out_fault = 1'b1;
      i_store_addr = $urandom;
      go(1'b1);
      chk("post", o_post_instr, 1'b1);
      chk("fmt", o_frame_fmt, 4'h3);
      chk("ea_valid", o_ea_valid, 1'b1);
      chk("frame_ea", o_frame_ea, i_store_addr);
      $display("test post done");
      for (int k = 0; k < 8; k++) begin
         @(negedge i_clk);
         i_ea_mode = fpx_ea_e'(k);
         go(1'b1);
         chk("fetch", o_fetch_clocks, 4'h1);
      end
      $display("test fetch done");
      // reset landing on an event must swallow it
      @(negedge i_clk);
      i_rst = 1'b1;
      i_arith_exc = 7'h01;
      go(1'b1);
      chk("exc", o_exc, 1'b0);
      chk("fetch", o_fetch_clocks, 4'h1);
      i_rst = 1'b0;
      $display("test rereset done");
      print_verdict();
   end
endmodule
`default_nettype wire
